// file: rtl/vap_dev_end.sv
// vap_dev_end: voice processor end of the serial audio port.
// assumes pclk 100 MHz; pipeline side streams run at the 16 kHz pipeline rate, or at the port rate in the usb accessory build.
`timescale 1ns/1ps
module vap_dev_end #(
  parameter bit usb_accessory_config = 1'b0,
  parameter bit int_master = 1'b0,
  parameter bit rate_48k = 1'b0,
  parameter bit ext_mclk = 1'b0,
  parameter int mclk_half = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  vap_link_if.dev link,
  input wire logic [31:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [31:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_overrun,
  output logic mclk_present
);
  // transport fixed by the usb_accessory_config parameter
  // usb accessory build always masters the port
  localparam bit MASTER = usb_accessory_config | int_master;
  // rate is a parameter only, no run-time control
  // half period picks 1.042 or 3.125 MHz, just above the nominal 1.024 or 3.072 MHz
  localparam logic [5:0] HALF = rate_48k ? vap_pkg::BCLK_HALF_48K : vap_pkg::BCLK_HALF_16K;
  // 3:1 conversion only where the 16 kHz pipeline meets a 48 kHz port
  // usb playback already runs at the port rate, so no conversion
  localparam logic [1:0] RATIO = (rate_48k && !usb_accessory_config)
                               ? 2'(vap_pkg::SRC_RATIO) : 2'h1;
  localparam logic [7:0] MDIV_LAST = 8'(mclk_half - 1);

  logic bc_s1, bc_s2, bc_s3, fs_s1, fs_s2, di_s1, di_s2;
  logic [5:0] hcnt;
  logic bclk_q, fs_q, fs_prev, first, sd_o;
  logic [4:0] slot_cnt;
  logic [31:0] hold_d, cur_tx, tx_sh, rx_sh, q1;
  logic hold_v, v1;
  logic [1:0] up_ph, dn_ph;
  logic [7:0] mdiv, m_idle;
  logic mclk_q, mc_s1, mc_s2, mc_s3;

  // pins pass two flops before use; bit clock edges compare the second and third flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc_s1 <= 1'b0;
      bc_s2 <= 1'b0;
      bc_s3 <= 1'b0;
    end else begin
      bc_s1 <= link.bit_clock;
      bc_s2 <= bc_s1;
      bc_s3 <= bc_s2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_s1 <= 1'b0;
      fs_s2 <= 1'b0;
      di_s1 <= 1'b0;
      di_s2 <= 1'b0;
    end else begin
      fs_s1 <= link.frame_select_clock;
      fs_s2 <= fs_s1;
      di_s1 <= link.serial_data_in;
      di_s2 <= di_s1;
    end
  end

  wire half_tick = (hcnt == HALF - 6'h01);
  wire slot_end = (slot_cnt == vap_pkg::SLOT_LAST);

  // bit clock divided down from pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt <= 6'h00;
      bclk_q <= 1'b0;
    end else begin
      hcnt <= half_tick ? 6'h00 : hcnt + 6'h01;
      bclk_q <= bclk_q ^ half_tick;
    end
  end

  // frame clock toggles every 32 falling bit clocks, 64 per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt <= 5'h00;
      fs_q <= 1'b0;
    end else if (half_tick && bclk_q) begin
      slot_cnt <= slot_cnt + 5'h01;
      fs_q <= fs_q ^ slot_end;
    end
  end

  // master uses its own clocks, slave uses the synchronised pins
  wire fall_ev = MASTER ? (half_tick & bclk_q) : (bc_s3 & ~bc_s2);
  wire rise_ev = MASTER ? (half_tick & ~bclk_q) : (bc_s2 & ~bc_s3);
  wire fs_now = MASTER ? (fs_q ^ slot_end) : fs_s2;
  wire fs_edge = fall_ev & (fs_now != fs_prev);
  wire left_start = fs_edge & ~fs_now;
  // only words that ended in the left slot are kept
  wire left_done = fall_ev & first & fs_now;

  wire take = left_start & (up_ph == 2'h0) & hold_v;
  wire [31:0] tx_word = take ? hold_d : cur_tx;
  wire accept = tx_valid & tx_ready;
  wire next_hold_v = accept | (hold_v & ~take);
  wire keep = left_done & (dn_ph == 2'h0);
  wire pop = rx_valid & rx_ready;
  wire buf_room = ~v1 | pop;

  // load at the frame clock edge, so the MSB leaves one bit later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_prev <= 1'b0;
      first <= 1'b0;
      sd_o <= 1'b0;
      tx_sh <= 32'h0000_0000;
    end else if (fall_ev) begin
      fs_prev <= fs_now;
      first <= fs_edge;
      sd_o <= tx_sh[31];
      tx_sh <= fs_edge ? tx_word : {tx_sh[30:0], 1'b0};
    end
  end

  // data sampled on rising bit clock, MSB first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh <= 32'h0000_0000;
    end else if (rise_ev) begin
      rx_sh <= {rx_sh[30:0], di_s2};
    end
  end

  // one sample held for the outgoing stream; repeated on underrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_d <= 32'h0000_0000;
      hold_v <= 1'b0;
      tx_ready <= 1'b1;
      cur_tx <= 32'h0000_0000;
    end else begin
      if (accept) begin
        hold_d <= tx_data;
      end
      hold_v <= next_hold_v;
      tx_ready <= ~next_hold_v;
      cur_tx <= tx_word;
    end
  end

  // rate converter phases, repeat out and decimate in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_ph <= 2'h0;
      dn_ph <= 2'h0;
    end else begin
      if (left_start) begin
        up_ph <= (up_ph == RATIO - 2'h1) ? 2'h0 : up_ph + 2'h1;
      end
      if (left_done) begin
        dn_ph <= (dn_ph == RATIO - 2'h1) ? 2'h0 : dn_ph + 2'h1;
      end
    end
  end

  // two-entry buffer toward the echo canceller; the link cannot be stalled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= 32'h0000_0000;
      rx_valid <= 1'b0;
      q1 <= 32'h0000_0000;
      v1 <= 1'b0;
    end else if (pop) begin
      rx_data <= v1 ? q1 : rx_sh;
      rx_valid <= v1 | keep;
      q1 <= rx_sh;
      v1 <= v1 & keep;
    end else if (keep && !rx_valid) begin
      rx_data <= rx_sh;
      rx_valid <= 1'b1;
    end else if (keep && !v1) begin
      q1 <= rx_sh;
      v1 <= 1'b1;
    end
  end

  // sticky until reset: a long stall past two words loses data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_overrun <= 1'b0;
    end else if (keep && !buf_room) begin
      rx_overrun <= 1'b1;
    end
  end

  // master clock generated here, or watched when supplied outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdiv <= 8'h00;
      mclk_q <= 1'b0;
    end else begin
      mdiv <= (mdiv == MDIV_LAST) ? 8'h00 : mdiv + 8'h01;
      mclk_q <= mclk_q ^ (mdiv == MDIV_LAST);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_s1 <= 1'b0;
      mc_s2 <= 1'b0;
      mc_s3 <= 1'b0;
    end else begin
      mc_s1 <= link.mclk;
      mc_s2 <= mc_s1;
      mc_s3 <= mc_s2;
    end
  end

  wire m_edge = mc_s2 ^ mc_s3;
  wire m_stuck = (m_idle == vap_pkg::MCLK_IDLE_LIMIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_idle <= vap_pkg::MCLK_IDLE_LIMIT;
      mclk_present <= 1'b0;
    end else begin
      m_idle <= m_edge ? 8'h00 : (m_stuck ? m_idle : m_idle + 8'h01);
      mclk_present <= ext_mclk ? ~m_stuck : 1'b1;
    end
  end

  // clock pins driven only as master
  assign link.bit_clock_dev_o = bclk_q;
  assign link.bit_clock_dev_oe = MASTER;
  assign link.frame_select_clock_dev_o = fs_q;
  assign link.frame_select_clock_dev_oe = MASTER;
  // processed or playback audio leaves on serial_data_out
  assign link.serial_data_out = sd_o;
  // pin is an output unless the external clock build is chosen
  assign link.mclk_dev_o = mclk_q;
  assign link.mclk_dev_oe = ~ext_mclk;
endmodule

// file: shared/vap_pkg.sv
// vap_pkg: constants shared by both ends of the voice serial audio port.
// assumes a 100 MHz pclk on both ends.
package vap_pkg;
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int FS_16K_HZ = 16_000;
  localparam int FS_48K_HZ = 48_000;
  localparam int PIPE_FS_HZ = FS_16K_HZ;
  localparam int BCLK_PER_FRAME = 64;
  localparam int SLOT_BITS = 32;
  localparam int SRC_RATIO = FS_48K_HZ / PIPE_FS_HZ;
  // half bit clock periods, rounded down so the clock is never slower than nominal
  localparam logic [5:0] BCLK_HALF_16K = 6'(SYS_CLK_HZ / (2 * BCLK_PER_FRAME * FS_16K_HZ));
  localparam logic [5:0] BCLK_HALF_48K = 6'(SYS_CLK_HZ / (2 * BCLK_PER_FRAME * FS_48K_HZ));
  localparam logic [4:0] SLOT_LAST = 5'(SLOT_BITS - 1);
  localparam logic [7:0] MCLK_IDLE_LIMIT = 8'hff;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TXREF = 8'h04;
  localparam logic [7:0] ADDR_RXPROC = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TXREF_RESET = 32'h0000_0000;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_FRESH_BIT = 1 - 1;
  localparam int STAT_LOST_BIT = 1;
endpackage

// file: shared/vap_link_if.sv
// vap_link_if: the serial audio wires between device end and host end.
// assumes the bench drives mclk_ext when the device takes an external master clock.
`timescale 1ns/1ps
interface vap_link_if;
  logic bit_clock_dev_o, bit_clock_dev_oe, bit_clock_host_o, bit_clock_host_oe;
  logic frame_select_clock_dev_o, frame_select_clock_dev_oe;
  logic frame_select_clock_host_o, frame_select_clock_host_oe;
  logic serial_data_in, serial_data_out;
  logic mclk_dev_o, mclk_dev_oe, mclk_ext;
  logic bit_clock, frame_select_clock, mclk;
  // undriven wire reads low
  assign bit_clock = bit_clock_dev_oe ? bit_clock_dev_o : (bit_clock_host_oe & bit_clock_host_o);
  assign frame_select_clock = frame_select_clock_dev_oe ? frame_select_clock_dev_o
                            : (frame_select_clock_host_oe & frame_select_clock_host_o);
  assign mclk = mclk_dev_oe ? mclk_dev_o : mclk_ext;
  modport dev (
    output bit_clock_dev_o, bit_clock_dev_oe, frame_select_clock_dev_o,
    output frame_select_clock_dev_oe, serial_data_out, mclk_dev_o, mclk_dev_oe,
    input bit_clock, frame_select_clock, serial_data_in, mclk
  );
  modport host (
    output bit_clock_host_o, bit_clock_host_oe, frame_select_clock_host_o,
    output frame_select_clock_host_oe, serial_data_in,
    input bit_clock, frame_select_clock, serial_data_out
  );
endinterface

// file: rtl/vap_host_end.sv
// vap_host_end: host processor end of the serial audio port, run by APB registers.
// assumes pclk 100 MHz; clocks are driven here only when host_master is set.
`timescale 1ns/1ps
module vap_host_end #(
  parameter bit host_master = 1'b1,
  parameter bit rate_48k = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  vap_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam logic [5:0] HALF = rate_48k ? vap_pkg::BCLK_HALF_48K : vap_pkg::BCLK_HALF_16K;

  logic bc_s1, bc_s2, bc_s3, fs_s1, fs_s2, di_s1, di_s2;
  logic [5:0] hcnt;
  logic bclk_q, fs_q, fs_prev, first, sd_o, enable, fresh, lost;
  logic [4:0] slot_cnt;
  logic [31:0] txref, rxproc, tx_sh, rx_sh;

  wire setup = psel & ~penable & ~pready;
  wire done = psel & penable & pready;
  wire [7:0] a = paddr[7:0];
  wire hit_ctrl = (a == vap_pkg::ADDR_CTRL);
  wire hit_tx = (a == vap_pkg::ADDR_TXREF);
  wire hit_rx = (a == vap_pkg::ADDR_RXPROC);
  wire hit_st = (a == vap_pkg::ADDR_STATUS);
  wire hit = (hit_ctrl | hit_tx | hit_rx | hit_st) & (paddr[31:8] == 24'h00_0000);
  wire [31:0] st_word = {30'h0000_0000, lost, fresh};
  wire [31:0] rd_val = hit_ctrl ? {31'h0000_0000, enable}
                     : hit_tx ? txref : hit_rx ? rxproc : hit_st ? st_word : 32'h0000_0000;
  wire rd_rx = done & ~pwrite & hit_rx;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= setup ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= vap_pkg::CTRL_RESET[vap_pkg::CTRL_EN_BIT];
      txref <= vap_pkg::TXREF_RESET;
    end else if (done && pwrite) begin
      if (hit_ctrl) begin
        enable <= pwdata[vap_pkg::CTRL_EN_BIT];
      end
      if (hit_tx) begin
        txref <= pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc_s1 <= 1'b0;
      bc_s2 <= 1'b0;
      bc_s3 <= 1'b0;
      fs_s1 <= 1'b0;
      fs_s2 <= 1'b0;
      di_s1 <= 1'b0;
      di_s2 <= 1'b0;
    end else begin
      bc_s1 <= link.bit_clock;
      bc_s2 <= bc_s1;
      bc_s3 <= bc_s2;
      fs_s1 <= link.frame_select_clock;
      fs_s2 <= fs_s1;
      di_s1 <= link.serial_data_out;
      di_s2 <= di_s1;
    end
  end

  wire half_tick = enable & (hcnt == HALF - 6'h01);
  wire slot_end = (slot_cnt == vap_pkg::SLOT_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt <= 6'h00;
      bclk_q <= 1'b0;
      slot_cnt <= 5'h00;
      fs_q <= 1'b0;
    end else begin
      hcnt <= (half_tick || !enable) ? 6'h00 : hcnt + 6'h01;
      bclk_q <= bclk_q ^ half_tick;
      if (half_tick && bclk_q) begin
        slot_cnt <= slot_cnt + 5'h01;
        fs_q <= fs_q ^ slot_end;
      end
    end
  end

  // host_master picks the host's own clocks, otherwise the synchronised pins are used
  wire fall_ev = host_master ? (half_tick & bclk_q) : (bc_s3 & ~bc_s2);
  wire rise_ev = host_master ? (half_tick & ~bclk_q) : (bc_s2 & ~bc_s3);
  wire fs_now = host_master ? (fs_q ^ slot_end) : fs_s2;
  wire fs_edge = fall_ev & (fs_now != fs_prev);
  wire left_done = enable & fall_ev & first & fs_now;
  // reference word in the left slot, right slot silent
  wire [31:0] tx_word = (enable & ~fs_now) ? txref : 32'h0000_0000;

  // MSB one bit clock after the frame clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_prev <= 1'b0;
      first <= 1'b0;
      sd_o <= 1'b0;
      tx_sh <= 32'h0000_0000;
    end else if (fall_ev) begin
      fs_prev <= fs_now;
      first <= fs_edge;
      sd_o <= tx_sh[31];
      tx_sh <= fs_edge ? tx_word : {tx_sh[30:0], 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh <= 32'h0000_0000;
    end else if (rise_ev) begin
      rx_sh <= {rx_sh[30:0], di_s2};
    end
  end

  // new word wins over a clearing read in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxproc <= 32'h0000_0000;
      fresh <= 1'b0;
      lost <= 1'b0;
    end else begin
      if (left_done) begin
        rxproc <= rx_sh;
      end
      fresh <= left_done | (fresh & ~rd_rx);
      lost <= (left_done & fresh & ~rd_rx) | (lost & ~(done & ~pwrite & hit_st));
    end
  end

  assign link.bit_clock_host_o = bclk_q;
  assign link.bit_clock_host_oe = host_master;
  assign link.frame_select_clock_host_o = fs_q;
  assign link.frame_select_clock_host_oe = host_master;
  assign link.serial_data_in = sd_o;
endmodule

// file: dv/vap_link_props.sv
// vap_link_props: timing checks on the serial audio wires between both ends.
// assumes a 16 kHz link, host end as clock master, device end as slave.
`timescale 1ns/1ps
module vap_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bit_clock,
  input wire logic frame_select_clock,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic mclk,
  input wire logic mclk_dev_oe,
  input wire logic bit_clock_dev_oe,
  input wire logic bit_clock_host_oe,
  input wire logic frame_select_clock_dev_oe,
  input wire logic frame_select_clock_host_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic bclk_q, fs_q, seen, seen_f, lw_ok;
  logic [7:0] run, rises, fcnt;
  logic [31:0] sdo_sh, left_w;
  wire bclk_rise = bit_clock & ~bclk_q;
  wire fs_edge = frame_select_clock ^ fs_q;
  wire fs_fall = fs_q & ~frame_select_clock;
  // first rise after a frame edge completes the slot just ended
  wire [31:0] sdo_word = {sdo_sh[30:0], serial_data_out};
  // run saturates so an idle clock never looks like a short half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_q <= 1'b0;
      fs_q <= 1'b0;
      // starts saturated so the first toggle after enable is not timed
      run <= 8'hff;
      rises <= 8'h00;
      fcnt <= 8'h00;
      seen <= 1'b0;
      seen_f <= 1'b0;
      sdo_sh <= 32'h0000_0000;
      left_w <= 32'h0000_0000;
      lw_ok <= 1'b0;
    end else begin
      if (bclk_rise) sdo_sh <= sdo_word;
      if (bclk_rise && (rises == 8'h00) && frame_select_clock && seen) begin
        left_w <= sdo_word;
        lw_ok <= 1'b1;
      end
      bclk_q <= bit_clock;
      fs_q <= frame_select_clock;
      if (bit_clock != bclk_q) run <= 8'h01;
      else if (run != 8'hff) run <= run + 8'h01;
      if (fs_edge) rises <= 8'h00;
      else if (bclk_rise) rises <= rises + 8'h01;
      if (fs_fall) fcnt <= 8'h00;
      else if (bclk_rise) fcnt <= fcnt + 8'h01;
      if (fs_edge) seen <= 1'b1;
      if (fs_fall) seen_f <= 1'b1;
    end
  end
  AST_BCLK_HALF: assert property (
    (bit_clock != bclk_q) && (run != 8'hff) |-> run == {2'b00, vap_pkg::BCLK_HALF_16K})
    else $error("bit clock half period wrong");
  AST_SLOT_32: assert property (
    fs_edge && seen |-> rises == 8'(vap_pkg::SLOT_BITS))
    else $error("slot length wrong");
  AST_FRAME_64: assert property (
    fs_fall && seen_f |-> fcnt == 8'(vap_pkg::BCLK_PER_FRAME))
    else $error("frame length wrong");
  AST_FS_ON_FALL: assert property (
    fs_edge |-> !bit_clock && bclk_q)
    else $error("frame select moved off a bit clock fall");
  AST_SDI_ON_FALL: assert property (
    $changed(serial_data_in) |-> !bit_clock)
    else $error("data in moved while bit clock high");
  AST_SDO_ON_FALL: assert property (
    $changed(serial_data_out) |-> !bit_clock)
    else $error("data out moved while bit clock high");
  AST_RIGHT_ZERO: assert property (
    bclk_rise && frame_select_clock && (rises != 8'h00) |-> !serial_data_in)
    else $error("right slot of reference not zero");
  AST_RIGHT_COPY: assert property (
    bclk_rise && (rises == 8'h00) && !frame_select_clock && lw_ok |-> sdo_word == left_w)
    else $error("right slot of outgoing audio differs from left");
  AST_ONE_DRIVER: assert property (
    !(bit_clock_dev_oe && bit_clock_host_oe) && !frame_select_clock_dev_oe
      && (bit_clock_host_oe == frame_select_clock_host_oe))
    else $error("clock driver roles wrong");
  AST_MCLK_RUNS: assert property (
    mclk_dev_oe |-> ##[1:16] $changed(mclk))
    else $error("master clock copy not toggling");
  cover property (fs_fall && seen_f);
  cover property (bclk_rise && serial_data_out);
  cover property (bclk_rise && serial_data_in);
endmodule

// file: dv/voice_i2s_audio_port_test.sv
// voice_i2s_audio_port_test: host end as master faces device end as slave.
// assumes 16 kHz link; host driven over APB, device streams by handshake.
`timescale 1ns/1ps
module voice_i2s_audio_port_test;
  localparam logic [31:0] REF_WORD = 32'ha5c3_0f71;
  localparam logic [31:0] OUT_WORD = 32'h3c96_e1d2;
  localparam int FRAME = 6144;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rx_data, rd;
  logic [31:0] tx_data = 32'h0000_0000;
  logic pready, pslverr, err, tx_valid = 1'b0, tx_ready, rx_valid, rx_ready = 1'b1;
  logic rx_overrun, mclk_present;
  int fails = 0, check_count = 0, cyc = 0;
  vap_link_if link ();
  initial link.mclk_ext = 1'b0;
  vap_dev_end #(.rate_48k(1'b0), .ext_mclk(1'b0), .mclk_half(4))
    vap_dev_end_inst (.pclk(pclk), .presetn(presetn),
    .link(link.dev), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_overrun(rx_overrun), .mclk_present(mclk_present));
  vap_host_end #(.host_master(1'b1), .rate_48k(1'b0)) vap_host_end_inst (.pclk(pclk),
    .presetn(presetn), .link(link.host), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  vap_link_props vap_link_props_inst (.pclk(pclk), .presetn(presetn),
    .bit_clock(link.bit_clock), .frame_select_clock(link.frame_select_clock),
    .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
    .mclk(link.mclk), .mclk_dev_oe(link.mclk_dev_oe),
    .bit_clock_dev_oe(link.bit_clock_dev_oe), .bit_clock_host_oe(link.bit_clock_host_oe),
    .frame_select_clock_dev_oe(link.frame_select_clock_dev_oe),
    .frame_select_clock_host_oe(link.frame_select_clock_host_oe));
  always #5 pclk = ~pclk;
  // ceiling well above the roughly 60k cycles the scenarios need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // slave flops update after this reads them, so values are those of the edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // no local limit: only the cycle ceiling ends a wait
  task automatic wait_rx();
    @(negedge pclk);
    while (rx_valid !== 1'b1) @(negedge pclk);
  endtask
  task automatic t_regs();
    chk("mclk_present", 32'h0000_0001, {31'h0, mclk_present});
    apb(1'b0, vap_pkg::ADDR_CTRL, 32'h0000_0000);
    chk("ctrl reset", vap_pkg::CTRL_RESET, rd);
    apb(1'b0, vap_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status reset", 32'h0000_0000, rd);
    apb(1'b1, vap_pkg::ADDR_TXREF, REF_WORD);
    apb(1'b1, 8'h14, 32'hffff_ffff);
    chk("unmapped write err", 32'h0000_0001, {31'h0, err});
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped read err", 32'h0000_0001, {31'h0, err});
    chk("unmapped read data", 32'h0000_0000, rd);
    apb(1'b0, vap_pkg::ADDR_TXREF, 32'h0000_0000);
    chk("txref readback", REF_WORD, rd);
  endtask
  // first word after enable may be a partial slot, so it is skipped
  task automatic t_ref();
    apb(1'b1, vap_pkg::ADDR_CTRL, 32'h0000_0001 << vap_pkg::CTRL_EN_BIT);
    wait_rx();
    repeat (2) begin
      wait_rx();
      chk("echo reference word", REF_WORD, rx_data);
    end
  endtask
  task automatic t_out();
    @(posedge pclk);
    tx_data <= OUT_WORD;
    tx_valid <= 1'b1;
    @(posedge pclk);
    while (tx_ready !== 1'b1) @(posedge pclk);
    tx_valid <= 1'b0;
    apb(1'b0, vap_pkg::ADDR_STATUS, 32'h0000_0000);
    apb(1'b0, vap_pkg::ADDR_RXPROC, 32'h0000_0000);
    repeat (3 * FRAME) @(posedge pclk);
    apb(1'b0, vap_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status fresh lost", (32'h0000_0001 << vap_pkg::STAT_FRESH_BIT)
      | (32'h0000_0001 << vap_pkg::STAT_LOST_BIT), rd);
    apb(1'b0, vap_pkg::ADDR_RXPROC, 32'h0000_0000);
    chk("processed word", OUT_WORD, rd);
    apb(1'b0, vap_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status cleared", 32'h0000_0000, rd);
  endtask
  // receiver stalls four frames: two words held, later ones dropped
  task automatic t_buf();
    @(posedge pclk);
    rx_ready <= 1'b0;
    repeat (4 * FRAME + 200) @(posedge pclk);
    @(negedge pclk);
    chk("overrun", 32'h0000_0001, {31'h0, rx_overrun});
    chk("held word", REF_WORD, rx_data);
    @(posedge pclk);
    rx_ready <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk("second entry valid", 32'h0000_0001, {31'h0, rx_valid});
    chk("second entry word", REF_WORD, rx_data);
    @(negedge pclk);
    chk("buffer empty", 32'h0000_0000, {31'h0, rx_valid});
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_ref();
    t_out();
    t_buf();
    results();
  end
endmodule
